// ===== rfc_defs.svh
// Register map, reset values, field positions and timing constants of the fan controller
`ifndef RFC_DEFS_SVH
`define RFC_DEFS_SVH

`define RFC_ADDR_DRIVE     8'h51
`define RFC_ADDR_LOOP_CFG  8'h52
`define RFC_ADDR_SPIN_CFG  8'h53
`define RFC_ADDR_STEP      8'h54
`define RFC_ADDR_FLOOR     8'h55
`define RFC_ADDR_STALL_THR 8'h56
`define RFC_ADDR_GOAL      8'h57
`define RFC_ADDR_MEAS      8'h58
`define RFC_ADDR_PART_ID   8'hFD

`define RFC_RST_DRIVE      8'h00
`define RFC_RST_LOOP_CFG   8'hCB
`define RFC_RST_SPIN_CFG   3'h1
`define RFC_RST_STEP       6'h10
`define RFC_RST_FLOOR      8'h80
`define RFC_RST_STALL_THR  8'hF5
`define RFC_RST_GOAL       8'hFA
`define RFC_RST_MEAS       8'hFF

`define RFC_LOOP_EN_BIT    7
`define RFC_RANGE_BIT      6
`define RFC_EDGES_MSB      4
`define RFC_EDGES_LSB      3
`define RFC_UPD_MSB        2
`define RFC_UPD_LSB        0
`define RFC_LOOP_CFG_MASK  8'hDF
`define RFC_LEVEL_BIT      2
`define RFC_DUR_MSB        1
`define RFC_DUR_LSB        0

`define RFC_GOAL_OFF       8'hFF
`define RFC_COUNT_SAT      8'hFF
`define RFC_DRIVE_FULL     8'hFF
`define RFC_LEVEL_60       8'h99
`define RFC_LEVEL_75       8'hBF

`define RFC_CLK_HZ         28'd200000000
`define RFC_REF_HZ         28'd32768
`define RFC_MS_PER_S       1000

`define RFC_UPD_MS_0       11'd100
`define RFC_UPD_MS_1       11'd200
`define RFC_UPD_MS_2       11'd300
`define RFC_UPD_MS_3       11'd400
`define RFC_UPD_MS_4       11'd500
`define RFC_UPD_MS_5       11'd800
`define RFC_UPD_MS_6       11'd1200
`define RFC_UPD_MS_7       11'd1600
`define RFC_SPIN_MS_0      11'd250
`define RFC_SPIN_MS_1      11'd500
`define RFC_SPIN_MS_2      11'd1000
`define RFC_SPIN_MS_3      11'd2000

`define RFC_EDGES_0        4'd3
`define RFC_EDGES_1        4'd5
`define RFC_EDGES_2        4'd7
`define RFC_EDGES_3        4'd9
`define RFC_PERIOD_MAX     12'hFFF

`endif

// ===== rfc_fan_ctrl.sv
// Closed-loop fan speed controller with spin-up, stall detection and register port
// Summary of operation
// - Loop enable 0 drives manual setting; 1 (default) regulates to target count.
// - Range bit selects 1x or 4x count multiplier; default 4x.
// - Edge field selects 3, 5, 7 or 9 sense edges per revolution.
// - Update field selects 100 to 1600 ms between drive updates.
// - Spin-up drive is 60% or 75% of full scale.
// - Spin duration 250 ms, 500 ms, 1 s or 2 s.
// - No valid speed by end of spin raises spin-up failure event.
// - Failed spin-up retries immediately while loop is active.
// - Each update changes drive by at most the 6-bit step value, or raises it straight to the floor if it is below it.
// - Loop updates never drive below minimum drive; the spin-up level ignores it, and target FFh drives 0.
// - Count above stall threshold means stalled; spin-up starts.
// - End of spin-up compares count with stall threshold.
// - Target above stall threshold is ignored; drive is held.
// - Target FFh turns drive off; other target writes start spin-up.
// - Speed count is 32.768 kHz periods per revolution.
// - Count registers hold upper bits, weights 2048 down to 16.
// - Too-slow fan reads FFh, also the reset value.
// - Spin, step, floor and threshold registers ignore writes when locked.
// - Read-only 8-bit part identification register.
// - Drive register reads applied level; loop-time writes kept for manual mode.
`timescale 1ns/1ps
`default_nettype none
`include "rfc_defs.svh"
module rfc_fan_ctrl #(
   parameter int unsigned   MS_CYCLES = `RFC_CLK_HZ / `RFC_MS_PER_S,
   parameter rfc_pkg::rfc_byte_t PART_ID = 8'hA5 // Arbitrary value
) (
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        SPEED_SENSE,
   input  wire logic        SW_LOCK,
   input  wire logic [7:0]  REG_ADDR,
   input  wire logic [7:0]  REG_WDATA,
   input  wire logic        REG_WR,
   input  wire logic        REG_RD,
   output logic [7:0]       REG_RDATA,
   output logic [7:0]       DRIVE_LEVEL,
   output logic             SPIN_FAIL
);
   import rfc_pkg::*;

   rfc_state_e  st_q;
   logic [7:0]  loop_cfg_q;
   logic [2:0]  spin_cfg_q;
   logic [5:0]  step_q;
   logic [7:0]  floor_q;
   logic [7:0]  thr_q;
   logic [7:0]  goal_q;
   logic [7:0]  manual_q;
   logic [7:0]  drive_q;
   logic [7:0]  meas;
   logic [7:0]  rdata_q;
   logic        fail_q;
   logic [27:0] ref_acc_q;
   logic [27:0] ref_sum;
   logic        ref_tick_q;
   logic [17:0] ms_cnt_q;
   logic        ms_tick_q;
   logic [10:0] tmr_q;
   logic [10:0] tmr_nxt;
   logic        sense_s1_q;
   logic        sense_s2_q;
   logic        sense_s3_q;
   logic        sense_edge;
   logic        loop_en;
   logic        goal_wr;
   logic [7:0]  spin_lvl;

   function automatic logic [10:0] upd_ms(input logic [2:0] c);
      case (c)
         3'h0:    upd_ms = `RFC_UPD_MS_0;
         3'h1:    upd_ms = `RFC_UPD_MS_1;
         3'h2:    upd_ms = `RFC_UPD_MS_2;
         3'h3:    upd_ms = `RFC_UPD_MS_3;
         3'h4:    upd_ms = `RFC_UPD_MS_4;
         3'h5:    upd_ms = `RFC_UPD_MS_5;
         3'h6:    upd_ms = `RFC_UPD_MS_6;
         default: upd_ms = `RFC_UPD_MS_7;
      endcase
   endfunction : upd_ms

   function automatic logic [10:0] spin_ms(input logic [1:0] c);
      case (c)
         2'h0:    spin_ms = `RFC_SPIN_MS_0;
         2'h1:    spin_ms = `RFC_SPIN_MS_1;
         2'h2:    spin_ms = `RFC_SPIN_MS_2;
         default: spin_ms = `RFC_SPIN_MS_3;
      endcase
   endfunction : spin_ms

   // One bounded step toward the target, clamped at full scale and at the floor
   function automatic logic [7:0] next_drive(input logic [7:0] d, input logic [7:0] m,
                                             input logic [7:0] g, input logic [5:0] s,
                                             input logic [7:0] f);
      logic [8:0] up;
      logic [8:0] lo;
      logic [7:0] r;
      up = {1'b0, d} + {3'b000, s};
      lo = {1'b0, f} + {3'b000, s};
      r  = d;
      if (m > g)
         r = up[8] ? `RFC_DRIVE_FULL : up[7:0];
      else if (m < g)
         r = ({1'b0, d} < lo) ? f : (d - {2'b00, s});
      if (r < f)
         r = f;
      next_drive = r;
   endfunction : next_drive

   assign loop_en  = loop_cfg_q[`RFC_LOOP_EN_BIT];
   assign goal_wr  = REG_WR && (REG_ADDR == `RFC_ADDR_GOAL);
   assign spin_lvl = spin_cfg_q[`RFC_LEVEL_BIT] ? `RFC_LEVEL_75 : `RFC_LEVEL_60;
   assign ref_sum  = ref_acc_q + `RFC_REF_HZ;
   assign tmr_nxt  = tmr_q + 11'd1;

   // Fractional divider keeps the reference at 32.768 kHz on average
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ref_acc_q  <= 28'd0;
         ref_tick_q <= 1'b0;
      end else if (ref_sum >= `RFC_CLK_HZ) begin
         ref_acc_q  <= ref_sum - `RFC_CLK_HZ;
         ref_tick_q <= 1'b1;
      end else begin
         ref_acc_q  <= ref_sum;
         ref_tick_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ms_cnt_q  <= 18'd0;
         ms_tick_q <= 1'b0;
      end else if (ms_cnt_q == 18'(MS_CYCLES - 1)) begin
         ms_cnt_q  <= 18'd0;
         ms_tick_q <= 1'b1;
      end else begin
         ms_cnt_q  <= ms_cnt_q + 18'd1;
         ms_tick_q <= 1'b0;
      end
   end

   // Sense pin is asynchronous; both edges count
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         // Idle level of the pulled-up pin, so reset release shows no false edge
         sense_s1_q <= 1'b1;
         sense_s2_q <= 1'b1;
         sense_s3_q <= 1'b1;
      end else begin
         sense_s1_q <= SPEED_SENSE;
         sense_s2_q <= sense_s1_q;
         sense_s3_q <= sense_s2_q;
      end
   end
   assign sense_edge = sense_s2_q ^ sense_s3_q;

   rfc_period_meter u_meter (
      .clk        (CLK),
      .rst_n      (RST_N),
      .ref_tick   (ref_tick_q),
      .sense_edge (sense_edge),
      .edges_sel  (loop_cfg_q[`RFC_EDGES_MSB:`RFC_EDGES_LSB]),
      .range_4x   (loop_cfg_q[`RFC_RANGE_BIT]),
      .count_q    (meas),
      .done_q     ()
   );

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         loop_cfg_q <= `RFC_RST_LOOP_CFG;
         spin_cfg_q <= `RFC_RST_SPIN_CFG;
         step_q     <= `RFC_RST_STEP;
         floor_q    <= `RFC_RST_FLOOR;
         thr_q      <= `RFC_RST_STALL_THR;
         goal_q     <= `RFC_RST_GOAL;
         manual_q   <= `RFC_RST_DRIVE;
      end else if (REG_WR) begin
         case (REG_ADDR)
            `RFC_ADDR_DRIVE:    manual_q   <= REG_WDATA;
            `RFC_ADDR_LOOP_CFG: loop_cfg_q <= REG_WDATA & `RFC_LOOP_CFG_MASK;
            `RFC_ADDR_GOAL:     goal_q     <= REG_WDATA;
            `RFC_ADDR_SPIN_CFG: if (!SW_LOCK) spin_cfg_q <= REG_WDATA[2:0];
            `RFC_ADDR_STEP:     if (!SW_LOCK) step_q <= REG_WDATA[5:0];
            `RFC_ADDR_FLOOR:    if (!SW_LOCK) floor_q <= REG_WDATA;
            `RFC_ADDR_STALL_THR: if (!SW_LOCK) thr_q <= REG_WDATA;
            default: ;
         endcase
      end
   end

   // Control state machine and drive level
   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         st_q    <= ST_OFF;
         drive_q <= `RFC_RST_DRIVE;
         tmr_q   <= 11'd0;
         fail_q  <= 1'b0;
      end else begin
         fail_q <= 1'b0;
         if (ms_tick_q)
            tmr_q <= tmr_nxt;
         if (!loop_en) begin
            st_q    <= ST_OFF;
            if (REG_WR && (REG_ADDR == `RFC_ADDR_DRIVE))
               drive_q <= REG_WDATA;
            else
               drive_q <= manual_q;
            tmr_q   <= 11'd0;
         end else if (goal_wr) begin
            tmr_q <= 11'd0;
            if (REG_WDATA == `RFC_GOAL_OFF) begin
               st_q    <= ST_OFF;
               drive_q <= 8'h00;
            end else begin
               st_q    <= ST_SPIN;
               drive_q <= spin_lvl;
            end
         end else begin
            case (st_q)
               ST_OFF: begin
                  tmr_q <= 11'd0;
                  if (goal_q == `RFC_GOAL_OFF) begin
                     drive_q <= 8'h00;
                  end else begin
                     st_q    <= ST_SPIN;
                     drive_q <= spin_lvl;
                  end
               end
               ST_SPIN: begin
                  drive_q <= spin_lvl;
                  if (ms_tick_q && tmr_nxt >= spin_ms(spin_cfg_q[`RFC_DUR_MSB:`RFC_DUR_LSB])) begin
                     tmr_q <= 11'd0;
                     if (meas <= thr_q)
                        st_q <= ST_RUN;
                     else
                        fail_q <= 1'b1;
                  end
               end
               ST_RUN: begin
                  if (meas > thr_q) begin
                     st_q    <= ST_SPIN;
                     drive_q <= spin_lvl;
                     tmr_q   <= 11'd0;
                  end else if (ms_tick_q && tmr_nxt >= upd_ms(loop_cfg_q[`RFC_UPD_MSB:`RFC_UPD_LSB])) begin
                     tmr_q <= 11'd0;
                     // Unreachable target would wind the drive to a rail; hold instead
                     if (goal_q <= thr_q)
                        drive_q <= next_drive(drive_q, meas, goal_q, step_q, floor_q);
                  end
               end
               default: st_q <= ST_OFF;
            endcase
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rdata_q <= 8'h00;
      end else if (REG_RD) begin
         case (REG_ADDR)
            `RFC_ADDR_DRIVE:     rdata_q <= drive_q;
            `RFC_ADDR_LOOP_CFG:  rdata_q <= loop_cfg_q;
            `RFC_ADDR_SPIN_CFG:  rdata_q <= {5'h00, spin_cfg_q};
            `RFC_ADDR_STEP:      rdata_q <= {2'b00, step_q};
            `RFC_ADDR_FLOOR:     rdata_q <= floor_q;
            `RFC_ADDR_STALL_THR: rdata_q <= thr_q;
            `RFC_ADDR_GOAL:      rdata_q <= goal_q;
            `RFC_ADDR_MEAS:      rdata_q <= meas;
            `RFC_ADDR_PART_ID:   rdata_q <= PART_ID;
            default:             rdata_q <= 8'h00;
         endcase
      end
   end

   assign REG_RDATA   = rdata_q;
   assign DRIVE_LEVEL = drive_q;
   assign SPIN_FAIL   = fail_q;
endmodule : rfc_fan_ctrl
`default_nettype wire

// ===== rfc_fan_ctrl_assertions.sv
// Port-level checker of the fan controller, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module rfc_fan_ctrl_checker #(
   parameter int unsigned        MS_CYCLES = 20,
   parameter rfc_pkg::rfc_byte_t PART_ID   = 8'hA5 // Arbitrary value
) (
   input wire logic       CLK,
   input wire logic       RST_N,
   input wire logic       SPEED_SENSE,
   input wire logic       SW_LOCK,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic       REG_WR,
   input wire logic       REG_RD,
   input wire logic [7:0] REG_RDATA,
   input wire logic [7:0] DRIVE_LEVEL,
   input wire logic       SPIN_FAIL
);
   import rfc_pkg::*;
   logic loop_en_q;
   // Shadow of the loop enable, so drive checks know the mode
   always_ff @(posedge CLK) begin
      if (!RST_N) loop_en_q <= 1'b1;
      else if (REG_WR && REG_ADDR == 8'h52) loop_en_q <= REG_WDATA[7];
   end
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   a_rdata_stands: assert property (!REG_RD |=> $stable(REG_RDATA))
      else $error("read data moved without a read");
   a_part_id: assert property (REG_RD && REG_ADDR == 8'hFD |=> REG_RDATA == PART_ID)
      else $error("part identifier wrong");
   a_step_width: assert property (REG_RD && REG_ADDR == 8'h54 |=> REG_RDATA[7:6] == 2'b00)
      else $error("step upper bits not zero");
   a_cfg_mask: assert property (REG_WR && REG_ADDR == 8'h52 ##1 !REG_WR ##1
      REG_RD && REG_ADDR == 8'h52 |=> REG_RDATA == ($past(REG_WDATA, 3) & 8'hDF))
      else $error("loop config readback wrong");
   a_goal_off: assert property (REG_WR && REG_ADDR == 8'h57 && REG_WDATA == 8'hFF && loop_en_q
      |=> DRIVE_LEVEL == 8'h00)
      else $error("drive not off after goal FF");
   a_goal_spin: assert property (REG_WR && REG_ADDR == 8'h57 && REG_WDATA != 8'hFF && loop_en_q
      |=> DRIVE_LEVEL inside {8'h99, 8'hBF})
      else $error("spin-up not started by goal write");
   a_manual_drive: assert property (REG_WR && REG_ADDR == 8'h51 && !loop_en_q
      |=> DRIVE_LEVEL == $past(REG_WDATA))
      else $error("manual drive not applied");
   a_fail_pulse: assert property (SPIN_FAIL |=> !SPIN_FAIL)
      else $error("spin failure longer than one cycle");
   a_fail_level: assert property (SPIN_FAIL |-> DRIVE_LEVEL inside {8'h99, 8'hBF})
      else $error("retry left the spin level");
   c_fail: cover property (SPIN_FAIL);
   c_goal_off: cover property (REG_WR && REG_ADDR == 8'h57 && REG_WDATA == 8'hFF);
   c_manual: cover property (REG_WR && REG_ADDR == 8'h51 && !loop_en_q);
endmodule : rfc_fan_ctrl_checker
bind rfc_fan_ctrl rfc_fan_ctrl_checker #(.MS_CYCLES(MS_CYCLES), .PART_ID(PART_ID))
   rfc_fan_ctrl_checker_inst (.CLK(CLK), .RST_N(RST_N), .SPEED_SENSE(SPEED_SENSE),
   .SW_LOCK(SW_LOCK), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
   .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .DRIVE_LEVEL(DRIVE_LEVEL), .SPIN_FAIL(SPIN_FAIL));
`default_nettype wire

// ===== rfc_fan_model.sv
// Behavioural cooling fan: speed-sense pin toggles while drive is applied
`timescale 1ns/1ps
`default_nettype none
module rfc_fan_model #(
   parameter int HALF = 700
) (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [7:0] drive,
   input  wire logic       stall,
   output logic            sense
);
   int cnt;
   initial sense = 1'b1;
   // Open-drain sense line with pull-up: a stopped fan leaves it high
   always @(posedge clk) begin
      if (!rst_n || stall || drive == 8'h00) begin
         cnt <= 0;
         sense <= 1'b1;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         sense <= ~sense;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule : rfc_fan_model
`default_nettype wire

// ===== rfc_period_meter.sv
// Speed-sense period meter: reference periods per revolution, scaled to the reading
`timescale 1ns/1ps
`default_nettype none
`include "rfc_defs.svh"
module rfc_period_meter (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ref_tick,
   input  wire logic        sense_edge,
   input  wire logic [1:0]  edges_sel,
   input  wire logic        range_4x,
   output logic [7:0]       count_q,
   output logic             done_q
);
   import rfc_pkg::*;

   logic [11:0] per_q;
   logic [3:0]  edg_q;
   logic        act_q;
   logic [3:0]  need;

   function automatic logic [3:0] edges_for(input logic [1:0] sel);
      case (sel)
         2'b00:   edges_for = `RFC_EDGES_0;
         2'b01:   edges_for = `RFC_EDGES_1;
         2'b10:   edges_for = `RFC_EDGES_2;
         default: edges_for = `RFC_EDGES_3;
      endcase
   endfunction : edges_for

   // Reading holds weights 2048..16 of the count times 1x or 4x
   function automatic logic [7:0] scale(input logic [11:0] p, input logic x4);
      if (x4)
         scale = (p[11:10] != 2'b00) ? `RFC_COUNT_SAT : p[9:2];
      else
         scale = p[11:4];
   endfunction : scale

   assign need = edges_for(edges_sel);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         per_q   <= 12'h000;
         edg_q   <= 4'h0;
         act_q   <= 1'b0;
         count_q <= `RFC_RST_MEAS;
         done_q  <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (sense_edge) begin
            if (!act_q || (edg_q + 4'd1 >= need)) begin
               if (act_q) begin
                  count_q <= scale(per_q, range_4x);
                  done_q  <= 1'b1;
               end
               act_q <= 1'b1;
               edg_q <= 4'd1;
               per_q <= 12'h000;
            end else begin
               edg_q <= edg_q + 4'd1;
            end
         end else if (ref_tick && act_q) begin
            if (per_q == `RFC_PERIOD_MAX) begin
               // Fan too slow or stopped: report saturation and rearm
               count_q <= `RFC_COUNT_SAT;
               done_q  <= 1'b1;
               act_q   <= 1'b0;
            end else begin
               per_q <= per_q + 12'd1;
            end
         end
      end
   end
endmodule : rfc_period_meter
`default_nettype wire

// ===== rfc_pkg.sv
// Types shared by the fan controller modules
package rfc_pkg;
   typedef enum logic [1:0] {
      ST_OFF  = 2'b00,
      ST_SPIN = 2'b01,
      ST_RUN  = 2'b10
   } rfc_state_e;
   typedef logic [7:0] rfc_byte_t;
endpackage : rfc_pkg

// ===== test_rpm_fan_speed_controller.sv
// Self-checking testbench of the fan speed controller
`timescale 1ns/1ps
`default_nettype none
module test_rpm_fan_speed_controller;
   localparam int MS = 20;
   localparam logic [7:0] PART_ID = 8'h3C; // Arbitrary value
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   logic       sense;
   logic       sw_lock = 1'b0;
   logic       stall = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic       reg_wr = 1'b0;
   logic       reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [7:0] drive_level;
   logic       spin_fail;
   int         fails = 0;
   int         checks = 0;
   int         n_fail = 0;
   always #2.5 clk = ~clk;
   always @(posedge clk) if (spin_fail === 1'b1) n_fail++;
   rfc_fan_ctrl #(.MS_CYCLES(MS), .PART_ID(PART_ID)) rfc_fan_ctrl_inst (.CLK(clk),
      .RST_N(rst_n), .SPEED_SENSE(sense), .SW_LOCK(sw_lock), .REG_ADDR(reg_addr),
      .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
      .DRIVE_LEVEL(drive_level), .SPIN_FAIL(spin_fail));
   // Rotor held stalled throughout, so the reading stays saturated from reset
   rfc_fan_model rfc_fan_model_inst (.clk(clk), .rst_n(rst_n), .drive(drive_level),
      .stall(stall), .sense(sense));
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      check($sformatf("reg %h", a), reg_rdata, exp);
   endtask : rd_chk
   // Waits for the drive to leave a level; a timeout shows as a wrong value later
   task automatic wait_drive(input logic [7:0] old, input int lim, output int n);
      n = 0;
      while (drive_level === old && n < lim) begin
         @(negedge clk);
         n++;
      end
   endtask : wait_drive
   task automatic t_reset_vals;
      logic [7:0] a [10] = '{8'h51, 8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'hFD, 8'h00};
      logic [7:0] e [10] = '{8'h99, 8'hCB, 8'h01, 8'h10, 8'h80, 8'hF5, 8'hFA, 8'hFF, PART_ID, 8'h00};
      check("spin drive", drive_level, 8'h99);
      for (int i = 0; i < 10; i++) rd_chk(a[i], e[i]);
   endtask : t_reset_vals
   task automatic t_lock;
      logic [7:0] e [4] = '{8'h01, 8'h10, 8'h80, 8'hF5};
      sw_lock = 1'b1;
      for (int i = 0; i < 4; i++) begin
         wr(8'h53 + 8'(i), 8'hFF);
         rd_chk(8'h53 + 8'(i), e[i]);
      end
      sw_lock = 1'b0;
   endtask : t_lock
   // Stalled fan: every attempt ends in a failure and a retry at the spin level
   task automatic t_spin_time;
      int n;
      int base;
      logic [7:0] lvl;
      int ms [3] = '{250, 500, 1000};
      for (int c = 0; c < 3; c++) begin
         lvl = c[0] ? 8'hBF : 8'h99;
         wr(8'h53, {5'h00, c[0], c[1:0]});
         wr(8'h57, 8'h80);
         check("spin level", drive_level, lvl);
         for (int k = 0; k < (c == 0 ? 2 : 1); k++) begin
            base = n_fail;
            n = 0;
            while (n_fail == base && n < ms[c] * MS + 10) begin
               @(negedge clk);
               n++;
            end
            check("spin time", 8'(n >= (ms[c] - 1) * MS - 3 && n <= ms[c] * MS + 3), 8'h01);
            check("retry level", drive_level, lvl);
         end
      end
   endtask : t_spin_time
   // Threshold FFh lets the saturated reading count as started, so the loop ramps up
   task automatic t_ramp;
      int n;
      logic [7:0] exp;
      wr(8'h56, 8'hFF);
      wr(8'h54, 8'hE0);
      rd_chk(8'h54, 8'h20);
      wr(8'h53, 8'h00);
      wr(8'h52, 8'hC8);
      wr(8'h57, 8'hFA);
      exp = 8'h99;
      for (int i = 0; i < 4; i++) begin
         wait_drive(drive_level, 400 * MS, n);
         exp = (i == 3) ? 8'hFF : exp + 8'h20;
         check("ramp step", drive_level, exp);
         check("update time", 8'(i == 0 || (n >= 99 * MS && n <= 100 * MS + 2)), 8'h01);
      end
      wait_drive(8'hFF, 150 * MS, n);
      check("drive cap", drive_level, 8'hFF);
      rd_chk(8'h51, 8'hFF);
      rd_chk(8'h58, 8'hFF);
   endtask : t_ramp
   task automatic t_goal_off;
      int base;
      wr(8'h57, 8'hFF);
      check("drive off", drive_level, 8'h00);
      base = n_fail;
      repeat (300 * MS) @(negedge clk);
      check("off held", drive_level, 8'h00);
      check("no fail", 8'(n_fail - base), 8'h00);
   endtask : t_goal_off
   task automatic t_manual;
      wr(8'h51, 8'h5A);
      check("loop kept", drive_level, 8'h00);
      wr(8'h52, 8'h48);
      @(negedge clk);
      check("manual", drive_level, 8'h5A);
      wr(8'h52, 8'h7F);
      rd_chk(8'h52, 8'h5F);
      wr(8'h51, 8'h37);
      check("manual", drive_level, 8'h37);
      rd_chk(8'h51, 8'h37);
   endtask : t_manual
   task automatic give_verdict;
      if (fails == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict
   initial begin
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      t_reset_vals;
      t_lock;
      t_spin_time;
      t_ramp;
      t_goal_off;
      t_manual;
      give_verdict;
   end
   initial begin
      repeat (90000) @(posedge clk);
      fails++;
      give_verdict;
   end
endmodule : test_rpm_fan_speed_controller
`default_nettype wire
